// >>> rtl/lctr_pkg.sv
// Purpose: Shared constants for the laser current tempco register bank
// Assumes: Command codes arrive already decoded from the serial link
// Notes:   Currents are given in microamps so half-values stay integral
package lctr_pkg;

   localparam int            CMD_W             = 8;
   localparam int            DATA_W            = 16;
   localparam int            COEFF_W           = 8;
   localparam int            RNG_W             = 2;
   localparam int            CUR_W             = 16;

   // Command codes of the three registers
   localparam logic [7:0]    CMD_FIRST_ORDER   = 8'h16;
   localparam logic [7:0]    CMD_SECOND_ORDER  = 8'h17;
   localparam logic [7:0]    CMD_MOD_SETTING   = 8'h19;

   // Field positions
   localparam int            COEFF_LSB         = 0;
   localparam int            COEFF_MSB         = 7;
   localparam int            RNG_LSB           = 10;
   localparam int            RNG_MSB           = 11;

   // Reset values
   localparam logic [7:0]    COEFF_RST         = 8'h00;
   localparam logic [1:0]    RNG_RST           = 2'h0;

   // Coefficient weights as negative powers of two
   localparam int            LINEAR_WEIGHT_EXP = 13;
   localparam int            QUAD_WEIGHT_EXP   = 18;

   // Peak-to-peak full scale per range step, in microamps
   localparam logic [15:0]   MOD_STEP_UA       = 16'h2328;

   typedef enum logic {
      LCTR_FIXED_CURRENT_REGULATION,
      LCTR_APC
   } lctr_mode_e;

endpackage

// >>> rtl/lctr_range_if.sv
// Purpose: Carries the modulation range code and its decoded currents
// Assumes: One clock domain
// Notes:   Decoder output is registered
`timescale 1ns/1ps
`default_nettype none
interface lctr_range_if;
   import lctr_pkg::*;
   logic [RNG_W-1:0] range_code;
   logic [CUR_W-1:0] peak_ua;
   logic [CUR_W-1:0] avg_ua;
   modport bank (output range_code, input peak_ua, input avg_ua);
   modport dec  (input range_code, output peak_ua, output avg_ua);
endinterface
`default_nettype wire

// >>> rtl/lctr_range_dec.sv
// Purpose: Decodes the modulation range code to full-scale currents
// Assumes: Range code is stable register state
// Notes:   Average is half of peak; output lags the code by one clock
`timescale 1ns/1ps
`default_nettype none
module lctr_range_dec
   import lctr_pkg::*;
(
   input  wire logic  clock,
   input  wire logic  srst,
   lctr_range_if.dec  rng
);
   logic [CUR_W-1:0] peak_d;
   logic [CUR_W-1:0] peak_q;
   logic [CUR_W-1:0] avg_q;

   // 9, 18, 27, 36 mA as steps of one range unit
   assign peak_d = CUR_W'(({14'h0, rng.range_code} + 16'h1) * MOD_STEP_UA);

   always_ff @(posedge clock) begin
      if (srst) begin
         peak_q <= MOD_STEP_UA;
         avg_q  <= MOD_STEP_UA >> 1;
      end else begin
         peak_q <= peak_d;
         avg_q  <= peak_d >> 1;
      end
   end

   assign rng.peak_ua = peak_q;
   assign rng.avg_ua  = avg_q;
endmodule
`default_nettype wire

// >>> rtl/lctr_regs.sv
// Purpose: Tempco and modulation range registers reached by command code
// Assumes: A serial front end presents decoded command-code accesses
//          The power-control mode input is a settled level, not a pulse
// Notes:   Coefficient routing follows the power-control mode input
//          Only the loop in use sees the coefficients; the other gets zero
//          A read and a write in one access store the write and return the
//          old word, so the host must not raise both strobes together
//          Bits 9:0 of the modulation word are not held here and read zero
//
// Notes on behaviour
// - First order coefficient, bits 7:0, signed
// - Second order coefficient, low byte, signed
// - Mode 0: linear coefficient drives bias, 2^-13
// - Mode 0: quadratic coefficient drives bias, 2^-18
// - Mode 1: linear coefficient drives monitor target
// - Mode 1: quadratic coefficient drives monitor target
// - Range codes give 9/18/27/36 mA peak
// - Average full scale is half of peak
// - Code 0x17 selects second order register
// - Code 0x19 selects modulation setting register
// - Code 0x16 selects first order register
`timescale 1ns/1ps
`default_nettype none
module lctr_regs
   import lctr_pkg::*;
(
   input  wire logic                clock,
   input  wire logic                srst,
   input  wire logic [CMD_W-1:0]    cmd_code,
   input  wire logic                cmd_wr,
   input  wire logic                cmd_rd,
   input  wire logic [DATA_W-1:0]   cmd_wdata,
   output logic      [DATA_W-1:0]   cmd_rdata,
   output logic                     cmd_ack,
   output logic                     cmd_hit,
   input  wire logic                apc_en,
   output logic signed [COEFF_W-1:0] bias_linear_coeff,
   output logic signed [COEFF_W-1:0] bias_quadratic_coeff,
   output logic signed [COEFF_W-1:0] monitor_linear_coeff,
   output logic signed [COEFF_W-1:0] monitor_quadratic_coeff,
   output logic      [RNG_W-1:0]    modulation_full_scale_select,
   output logic      [CUR_W-1:0]    modulation_peak_ua,
   output logic      [CUR_W-1:0]    modulation_avg_ua,
   output logic                     apc_mode
);
   lctr_range_if rng ();

   logic [COEFF_W-1:0] first_q;
   logic [COEFF_W-1:0] second_q;
   logic [RNG_W-1:0]   range_q;
   logic [DATA_W-1:0]  rdata_d;
   logic [DATA_W-1:0]  rdata_q;
   logic               ack_q;
   logic               hit_q;
   lctr_mode_e         mode;

   logic sel_first;
   logic sel_second;
   logic sel_mod;
   logic sel_any;
   logic wr_first;
   logic wr_second;
   logic wr_mod;

   // Next values, read-back words and answer terms
   logic               req;
   logic               monitor_loop;
   logic [COEFF_W-1:0] first_d;
   logic [COEFF_W-1:0] second_d;
   logic [RNG_W-1:0]   range_d;
   logic [DATA_W-1:0]  first_word;
   logic [DATA_W-1:0]  second_word;
   logic [DATA_W-1:0]  mod_word;
   logic [DATA_W-1:0]  rdata_pick;
   logic               ack_d;
   logic               hit_d;

   // Address decode on command code
   assign sel_first  = (cmd_code == CMD_FIRST_ORDER);
   assign sel_second = (cmd_code == CMD_SECOND_ORDER);
   assign sel_mod    = (cmd_code == CMD_MOD_SETTING);
   assign sel_any    = sel_first | sel_second | sel_mod;
   assign wr_first   = cmd_wr & sel_first;
   assign wr_second  = cmd_wr & sel_second;
   assign wr_mod     = cmd_wr & sel_mod;

   // Writes keep only the defined field of the word
   assign first_d    = cmd_wdata[COEFF_MSB:COEFF_LSB];
   assign second_d   = cmd_wdata[COEFF_MSB:COEFF_LSB];
   assign range_d    = cmd_wdata[RNG_MSB:RNG_LSB];

   // Read-back words; reserved positions are tied to zero
   // The nominal setting below the range field has no storage here
   assign first_word  = {{(DATA_W-COEFF_W){1'b0}}, first_q};
   assign second_word = {{(DATA_W-COEFF_W){1'b0}}, second_q};
   assign mod_word    = {{(DATA_W-RNG_MSB-1){1'b0}}, range_q, {RNG_LSB{1'b0}}};

   // Every access is answered, a hit only on a mapped code
   assign req         = cmd_rd | cmd_wr;
   assign ack_d       = req;
   assign hit_d       = req & sel_any;

   // Read data is gated per bit, so a write answers with all zeros
   for (genvar b = 0; b < DATA_W; b++) begin : g_rbit
      assign rdata_pick[b] = cmd_rd & rdata_d[b];
   end

   // Upper bits are dropped on write and read back as zero
   always_comb begin
      if (sel_first) begin
         rdata_d = first_word;
      end else if (sel_second) begin
         rdata_d = second_word;
      end else if (sel_mod) begin
         rdata_d = mod_word;
      end else begin
         rdata_d = 16'h0000;
      end
   end

   // Each field register is written only by its own command code
   always_ff @(posedge clock) begin
      if (srst) begin
         first_q <= COEFF_RST;
      end else if (wr_first) begin
         first_q <= first_d;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         second_q <= COEFF_RST;
      end else if (wr_second) begin
         second_q <= second_d;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         range_q <= RNG_RST;
      end else if (wr_mod) begin
         range_q <= range_d;
      end
   end

   // Read data stands for the ack cycle only
   always_ff @(posedge clock) begin
      if (srst) begin
         rdata_q <= 16'h0000;
      end else begin
         rdata_q <= rdata_pick;
      end
   end

   // One ack per access keeps the host's count of answers exact
   always_ff @(posedge clock) begin
      if (srst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= ack_d;
      end
   end

   // Hit is low for an unmapped code so the host can spot a bad command
   always_ff @(posedge clock) begin
      if (srst) begin
         hit_q <= 1'b0;
      end else begin
         hit_q <= hit_d;
      end
   end

   assign cmd_rdata = rdata_q;
   assign cmd_ack   = ack_q;
   assign cmd_hit   = hit_q;

   // Mode picks which current loop sees the coefficients; the idle loop
   // gets zero so it never applies a stale slope.
   assign mode         = apc_en ? LCTR_APC : LCTR_FIXED_CURRENT_REGULATION;
   assign monitor_loop = (mode == LCTR_APC);
   assign apc_mode     = monitor_loop;

   always_comb begin
      bias_linear_coeff       = '0;
      bias_quadratic_coeff    = '0;
      monitor_linear_coeff    = '0;
      monitor_quadratic_coeff = '0;
      case (mode)
         LCTR_FIXED_CURRENT_REGULATION: begin
            bias_linear_coeff    = signed'(first_q);
            bias_quadratic_coeff = signed'(second_q);
         end
         LCTR_APC: begin
            monitor_linear_coeff    = signed'(first_q);
            monitor_quadratic_coeff = signed'(second_q);
         end
         default: begin
            bias_linear_coeff       = '0;
            bias_quadratic_coeff    = '0;
            monitor_linear_coeff    = '0;
            monitor_quadratic_coeff = '0;
         end
      endcase
   end

   assign rng.range_code               = range_q;
   assign modulation_full_scale_select = range_q;

   // Full-scale currents are registered in the decoder, so they trail a
   // range write by one clock; a reader of the currents must allow for it.
   // The extra stage keeps the multiply off the register read path.
   lctr_range_dec u_range_dec (
      .clock (clock),
      .srst  (srst),
      .rng   (rng)
   );

   assign modulation_peak_ua = rng.peak_ua;
   assign modulation_avg_ua  = rng.avg_ua;
endmodule
`default_nettype wire

// >>> dv/lctr_host.sv
// Purpose: Host model issuing command-code accesses to the bank
// Assumes: Strobes are one-cycle pulses, answer one clock later
// Notes:   Idle write data shows the inverse of the last word
`timescale 1ns/1ps
`default_nettype none
module lctr_host
   import lctr_pkg::*;
(
   input  wire logic              clock,
   input  wire logic [DATA_W-1:0] cmd_rdata,
   input  wire logic              cmd_ack,
   input  wire logic              cmd_hit,
   output logic      [CMD_W-1:0]  cmd_code = 8'h00,
   output logic                   cmd_wr = 1'b0,
   output logic                   cmd_rd = 1'b0,
   output logic      [DATA_W-1:0] cmd_wdata = 16'h0000
);
   task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [16:0] r);
      int n;
      n = 0;
      r = 'x;
      @(posedge clock);
      cmd_wr    <= w;
      cmd_rd    <= !w;
      cmd_code  <= c;
      cmd_wdata <= d;
      @(posedge clock);
      cmd_wr    <= 1'b0;
      cmd_rd    <= 1'b0;
      cmd_wdata <= ~d;
      // Sample off the edge so the answer has settled
      do begin
         @(negedge clock);
         n++;
      end while (cmd_ack !== 1'b1 && n < 4);
      if (cmd_ack === 1'b1)
         r = {cmd_hit, cmd_rdata};
   endtask
endmodule
`default_nettype wire

// >>> dv/lctr_regs_asserts.sv
// Purpose: Port-level checks on the tempco register bank
// Assumes: One clock, synchronous reset
// Notes:   Coefficient routing is checked by the bench
`timescale 1ns/1ps
`default_nettype none
module lctr_regs_chk
   import lctr_pkg::*;
(
   input wire logic [CMD_W-1:0]  cmd_code,
   input wire logic              clock,
   input wire logic              srst,
   input wire logic              cmd_wr,
   input wire logic              cmd_rd,
   input wire logic [DATA_W-1:0] cmd_wdata,
   input wire logic [DATA_W-1:0] cmd_rdata,
   input wire logic              cmd_ack,
   input wire logic              cmd_hit,
   input wire logic [RNG_W-1:0]  modulation_full_scale_select,
   input wire logic [CUR_W-1:0]  modulation_peak_ua,
   input wire logic [CUR_W-1:0]  modulation_avg_ua
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   wire req  = cmd_wr | cmd_rd;
   wire hit  = cmd_code inside {CMD_FIRST_ORDER, CMD_SECOND_ORDER, CMD_MOD_SETTING};
   wire wr19 = cmd_wr && cmd_code == CMD_MOD_SETTING;
   sequence s_taken; ##1 cmd_ack && cmd_hit; endsequence
   property p_ack; 1 |=> cmd_ack == $past(req); endproperty
   a_ack: assert property (p_ack) else $error("ack not one clock after request");
   property p_hit; req && hit |-> s_taken; endproperty
   a_hit: assert property (p_hit) else $error("mapped code not hit");
   property p_miss; req && !hit |=> cmd_ack && !cmd_hit; endproperty
   a_miss: assert property (p_miss) else $error("unmapped code hit");
   property p_resv; cmd_rd |=> cmd_rdata[15:12] == 4'h0 && cmd_rdata[9:8] == 2'h0; endproperty
   a_resv: assert property (p_resv) else $error("reserved bits nonzero");
   property p_sel; wr19 |=> modulation_full_scale_select == $past(cmd_wdata[11:10]); endproperty
   a_sel: assert property (p_sel) else $error("range field not stored");
   property p_hold; !srst && !wr19 |=> $stable(modulation_full_scale_select); endproperty
   a_hold: assert property (p_hold) else $error("range field changed");
   property p_peak;
      !srst |=> modulation_peak_ua == MOD_STEP_UA * ({14'h0, $past(modulation_full_scale_select)} + 16'h1);
   endproperty
   a_peak: assert property (p_peak) else $error("peak full scale wrong");
   property p_avg; 1 |-> modulation_avg_ua == modulation_peak_ua >> 1; endproperty
   a_avg: assert property (p_avg) else $error("average not half of peak");
endmodule
bind lctr_regs lctr_regs_chk u_chk (.*);
`default_nettype wire

// >>> dv/lctr_regs_tb.sv
// Purpose: Self-checking bench for the tempco register bank
// Assumes: Host model makes every command access
// Notes:   Table rows first, then range, mode and reset cases
`timescale 1ns/1ps
`default_nettype none
module lctr_regs_tb;
   import lctr_pkg::*;
   typedef struct packed {logic w; logic [7:0] c; logic [15:0] d; logic [16:0] e;} lctr_row_s;
   logic                      clock = 1'b0;
   logic                      srst = 1'b1;
   logic                      apc_en = 1'b0;
   logic                      cmd_wr, cmd_rd, cmd_ack, cmd_hit, apc_mode;
   logic        [CMD_W-1:0]   cmd_code;
   logic        [DATA_W-1:0]  cmd_wdata, cmd_rdata, modulation_peak_ua, modulation_avg_ua;
   logic        [RNG_W-1:0]   modulation_full_scale_select;
   logic signed [COEFF_W-1:0] bias_linear_coeff, bias_quadratic_coeff;
   logic signed [COEFF_W-1:0] monitor_linear_coeff, monitor_quadratic_coeff;
   int                        fails = 0;
   int                        num_checks = 0;
   lctr_row_s                 rows [8] = '{'{1'b1, 8'h16, 16'hff80, 17'h10000},
      '{1'b0, 8'h16, 16'h0000, 17'h10080}, '{1'b1, 8'h17, 16'ha57f, 17'h10000},
      '{1'b0, 8'h17, 16'h0000, 17'h1007f}, '{1'b1, 8'h19, 16'hffff, 17'h10000},
      '{1'b0, 8'h19, 16'h0000, 17'h10c00}, '{1'b1, 8'h18, 16'h1234, 17'h00000},
      '{1'b0, 8'h18, 16'h0000, 17'h00000}};
   lctr_host host (.*);
   lctr_regs dut (.*);
   always #4 clock = ~clock;
   task automatic chk(input logic [16:0] got, input logic [16:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      logic [16:0] r;
      repeat (4) @(posedge clock);
      srst <= 1'b0;
      foreach (rows[i]) begin
         host.acc(rows[i].w, rows[i].c, rows[i].d, r);
         chk(r, rows[i].e);
      end
      $display("table rows done");
      for (int k = 0; k < 4; k++) begin
         host.acc(1'b1, CMD_MOD_SETTING, {4'h0, k[1:0], 10'h000}, r);
         @(negedge clock);
         chk({1'b0, modulation_peak_ua}, 17'(MOD_STEP_UA * (k + 1)));
         chk({1'b0, modulation_avg_ua}, 17'(MOD_STEP_UA * (k + 1) / 2));
         chk({15'h0, modulation_full_scale_select}, 17'(k));
      end
      $display("range codes done");
      for (int m = 0; m < 2; m++) begin
         @(posedge clock);
         apc_en <= m[0];
         @(negedge clock);
         chk({1'b0, bias_linear_coeff, monitor_linear_coeff}, m ? 17'h00080 : 17'h08000);
         chk({1'b0, bias_quadratic_coeff, monitor_quadratic_coeff}, m ? 17'h0007f : 17'h07f00);
         chk({16'h0, apc_mode}, 17'(m));
      end
      $display("mode routing done");
      @(posedge clock);
      srst <= 1'b1;
      @(posedge clock);
      srst <= 1'b0;
      host.acc(1'b0, CMD_FIRST_ORDER, 16'h0000, r);
      chk(r, 17'h10000);
      chk({1'b0, modulation_peak_ua}, 17'(MOD_STEP_UA));
      chk({1'b0, monitor_linear_coeff, monitor_quadratic_coeff}, 17'h00000);
      $display("reset case done");
      wrap_up;
   end
   // Whole run needs well under 300 clocks
   initial begin
      repeat (2000) @(posedge clock);
      fails++;
      wrap_up;
   end
endmodule
`default_nettype wire
